/* File: rms_map.vh */
// Register map, field positions, reset values and timing constants of the mode sequencer
`ifndef RMS_MAP_VH
`define RMS_MAP_VH

// ---------------------------------------------------------------
// Register addresses
// ---------------------------------------------------------------
`define RMS_ADDR_DEV_STATE   7'h02
`define RMS_ADDR_FLAGS_A     7'h03
`define RMS_ADDR_FLAGS_B     7'h04
`define RMS_ADDR_MASK_A      7'h05
`define RMS_ADDR_MASK_B      7'h06
`define RMS_ADDR_OP_MODE     7'h07
`define RMS_ADDR_CAL_CTRL    7'h08
`define RMS_ADDR_FREQ_BAND   7'h75
`define RMS_ADDR_FREQ_HI     7'h76
`define RMS_ADDR_FREQ_LO     7'h77
`define RMS_ADDR_HOP_STEP    7'h79
`define RMS_ADDR_HOP_CHAN    7'h7A

// ---------------------------------------------------------------
// Operating mode and calibration control fields
// ---------------------------------------------------------------
`define RMS_OPM_XTAL_KEEP    0
`define RMS_OPM_SYNTH_KEEP   1
`define RMS_OPM_RX_REQ       2
`define RMS_OPM_BATT_MON     5
`define RMS_OPM_WAKE_TMR     6
`define RMS_OPM_SOFT_RST     7
`define RMS_OPM_RESET        8'h01
`define RMS_CAL_VCO_EN       0
`define RMS_CAL_RESET        8'h01

// ---------------------------------------------------------------
// Interrupt fields
// ---------------------------------------------------------------
`define RMS_FLAGS_A_USED     8'h98
`define RMS_MASK_A_RESET     8'h00
`define RMS_MASK_B_RESET     8'h01
`define RMS_FLAG_B_CHIP_RDY  1
`define RMS_FLAG_B_POWER_UP  0

// ---------------------------------------------------------------
// Chip power state codes
// ---------------------------------------------------------------
`define RMS_CPS_IDLE         2'b00
`define RMS_CPS_RX           2'b01
`define RMS_CPS_TUNE         2'b10

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define RMS_CLK_MHZ          250
`define RMS_PLL_SETTLE_US    100
`define RMS_PLL_TOTAL_US     200
`define RMS_VCO_BIAS_US      10
`define RMS_XTAL_START_US    20
`define RMS_SETTLE_CYC       (`RMS_PLL_SETTLE_US * `RMS_CLK_MHZ)
`define RMS_BIAS_CYC         (`RMS_VCO_BIAS_US * `RMS_CLK_MHZ)
`define RMS_CAL_CYC          ((`RMS_PLL_TOTAL_US - `RMS_PLL_SETTLE_US - `RMS_VCO_BIAS_US) * `RMS_CLK_MHZ)
`define RMS_XTAL_CYC         (`RMS_XTAL_START_US * `RMS_CLK_MHZ)

`endif

/* File: rms_timer.v */
// Loadable down counter used for the sequencer waits
`timescale 1ns/1ps
module rms_timer #(
  parameter TW = 16
) (
  input  wire          clk,
  input  wire          reset,
  input  wire          load,
  input  wire [TW-1:0] load_val,
  output reg           done_q
);

  reg [TW-1:0] cnt_q;

  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      cnt_q  <= {TW{1'b0}};
      done_q <= 1'b0;
    end else if (load) begin
      cnt_q  <= load_val;
      done_q <= 1'b0;
    end else if (cnt_q != {TW{1'b0}}) begin
      cnt_q  <= cnt_q - {{(TW-1){1'b0}}, 1'b1};
      done_q <= (cnt_q == {{(TW-1){1'b0}}, 1'b1});
    end else begin
      done_q <= 1'b0;
    end
  end

endmodule // rms_timer

/* File: rms_spi_slave.v */
// Serial register port: pin synchronisers, 16-bit framing with burst, read data shifter
`timescale 1ns/1ps
module rms_spi_slave (
  input  wire       clk,
  input  wire       reset,
  input  wire       sclk,
  input  wire       sdi,
  input  wire       sel_n,
  input  wire [7:0] rdata,
  output reg        wr_stb_q,
  output reg        rd_stb_q,
  output reg  [6:0] addr_q,
  output reg  [7:0] wdata_q,
  output reg        sdo_q
);

  reg [2:0] sclk_s;
  reg [1:0] sdi_s;
  reg [1:0] sel_n_s;
  reg [2:0] bit_cnt_q;
  reg [6:0] shift_in_q;
  reg [7:0] shift_out_q;
  reg       first_q;
  reg       is_write_q;
  reg       load_pend_q;
  wire      rise = sclk_s[1] & ~sclk_s[2];
  wire      fall = ~sclk_s[1] & sclk_s[2];
  wire [7:0] byte_in = {shift_in_q, sdi_s[1]};

  // ---------------------------------------------------------------
  // Synchronisers
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      sclk_s  <= 3'h0;
      sdi_s   <= 2'h0;
      sel_n_s <= 2'h3;
    end else begin
      sclk_s  <= {sclk_s[1:0], sclk};
      sdi_s   <= {sdi_s[0], sdi};
      sel_n_s <= {sel_n_s[0], sel_n};
    end
  end

  // ---------------------------------------------------------------
  // Framing
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      bit_cnt_q   <= 3'h0;
      shift_in_q  <= 7'h00;
      shift_out_q <= 8'h00;
      first_q     <= 1'b1;
      is_write_q  <= 1'b0;
      load_pend_q <= 1'b0;
      wr_stb_q    <= 1'b0;
      rd_stb_q    <= 1'b0;
      addr_q      <= 7'h00;
      wdata_q     <= 8'h00;
      sdo_q       <= 1'b1;
    end else begin
      wr_stb_q <= 1'b0;
      rd_stb_q <= 1'b0;
      if (sel_n_s[1]) begin
        // Idle line is pulled high
        bit_cnt_q   <= 3'h0;
        first_q     <= 1'b1;
        load_pend_q <= 1'b0;
        sdo_q       <= 1'b1;
      end else begin
        if (rise) begin
          shift_in_q <= byte_in[6:0];
          bit_cnt_q  <= bit_cnt_q + 3'h1;
          if (bit_cnt_q == 3'h7) begin
            if (first_q) begin
              first_q    <= 1'b0;
              is_write_q <= byte_in[7];
              addr_q     <= byte_in[6:0];
              if (!byte_in[7]) begin
                rd_stb_q    <= 1'b1;
                load_pend_q <= 1'b1;
              end
            end else if (is_write_q) begin
              wr_stb_q <= 1'b1;
              wdata_q  <= byte_in;
            end else begin
              // Burst read: fetch the next address
              addr_q      <= addr_q + 7'h01;
              rd_stb_q    <= 1'b1;
              load_pend_q <= 1'b1;
            end
          end
        end
        if (wr_stb_q) begin
          addr_q <= addr_q + 7'h01;
        end
        if (fall && !first_q && !is_write_q) begin
          if (load_pend_q) begin
            sdo_q       <= rdata[7];
            shift_out_q <= {rdata[6:0], 1'b0};
            load_pend_q <= 1'b0;
          end else begin
            sdo_q       <= shift_out_q[7];
            shift_out_q <= {shift_out_q[6:0], 1'b0};
          end
        end
      end
    end
  end

endmodule // rms_spi_slave

/* File: rms_mode_seq.v */
// Operating mode state machine, receive sequencer, status and interrupt registers
`timescale 1ns/1ps
`include "rms_map.vh"

module rms_mode_seq #(
  parameter SETTLE_CYC = `RMS_SETTLE_CYC,
  parameter BIAS_CYC   = `RMS_BIAS_CYC,
  parameter CAL_CYC    = `RMS_CAL_CYC,
  parameter XTAL_CYC   = `RMS_XTAL_CYC,
  parameter TW         = 16
) (
  input  wire       clk,
  input  wire       reset,
  input  wire       sclk,
  input  wire       sdi,
  input  wire       sel_n,
  input  wire [7:0] evt_a,
  input  wire [7:0] evt_b,
  input  wire       fifo_overflow,
  input  wire       fifo_underflow,
  input  wire       rx_fifo_empty,
  input  wire       freq_error,
  input  wire       vco_cal_done,
  input  wire       adc_cal_done,
  output wire       sdo,
  output reg        irq_n_q,
  output reg        low_power_regulator_q,
  output reg        main_regulator_q,
  output reg        wake_timer_en_q,
  output reg        batt_detect_en_q,
  output reg        xtal_en_q,
  output reg        pll_en_q,
  output reg        vco_cal_req_q,
  output reg        rx_frontend_en_q,
  output reg        adc_cal_req_q,
  output reg        modem_rx_en_q
);

  // ---------------------------------------------------------------
  // States
  // ---------------------------------------------------------------
  localparam [3:0] S_OFF     = 4'h0;
  localparam [3:0] S_REG     = 4'h1;
  localparam [3:0] S_XTAL    = 4'h2;
  localparam [3:0] S_XTAL_ON = 4'h3;
  localparam [3:0] S_PLL     = 4'h4;
  localparam [3:0] S_BIAS    = 4'h5;
  localparam [3:0] S_CAL     = 4'h6;
  localparam [3:0] S_SETTLE  = 4'h7;
  localparam [3:0] S_LOCK    = 4'h8;
  localparam [3:0] S_RXEN    = 4'h9;
  localparam [3:0] S_ADCCAL  = 4'hA;
  localparam [3:0] S_RX      = 4'hB;

  localparam [TW-1:0] SETTLE_LD = SETTLE_CYC[TW-1:0];
  localparam [TW-1:0] BIAS_LD   = BIAS_CYC[TW-1:0];
  localparam [TW-1:0] CAL_LD    = CAL_CYC[TW-1:0];
  localparam [TW-1:0] XTAL_LD   = XTAL_CYC[TW-1:0];

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  reg  [7:0]    op_mode_q;
  reg  [7:0]    cal_ctrl_q;
  reg  [7:0]    mask_a_q;
  reg  [7:0]    mask_b_q;
  reg  [7:0]    flags_a_q;
  reg  [7:0]    flags_b_q;
  reg  [7:0]    rdata_q;
  reg  [3:0]    state_q;
  reg  [3:0]    state_d;
  reg           freq_chg_q;
  reg           por_pend_q;
  reg           tmr_load;
  reg  [TW-1:0] tmr_val;
  reg           chip_rdy_evt;
  wire          wr_stb;
  wire          rd_stb;
  wire [6:0]    spi_addr;
  wire [7:0]    spi_wdata;
  wire          tmr_done;
  wire          soft_rst;
  wire          want_main;
  wire          want_pll;
  wire          want_rx;
  wire          sleep_sel;
  wire          sensor_sel;
  wire [7:0]    set_a;
  wire [7:0]    set_b;
  wire [1:0]    cps;

  // ---------------------------------------------------------------
  // Register address decode helper
  // ---------------------------------------------------------------
  function hit;
    input [6:0] a;
    input [6:0] ref_addr;
    begin
      hit = (a == ref_addr);
    end
  endfunction

  // ---------------------------------------------------------------
  // Submodules
  // ---------------------------------------------------------------
  rms_spi_slave u_spi (
    .clk      (clk),
    .reset    (reset),
    .sclk     (sclk),
    .sdi      (sdi),
    .sel_n    (sel_n),
    .rdata    (rdata_q),
    .wr_stb_q (wr_stb),
    .rd_stb_q (rd_stb),
    .addr_q   (spi_addr),
    .wdata_q  (spi_wdata),
    .sdo_q    (sdo)
  );

  rms_timer #(
    .TW (TW)
  ) u_tmr (
    .clk      (clk),
    .reset    (reset),
    .load     (tmr_load),
    .load_val (tmr_val),
    .done_q   (tmr_done)
  );

  // ---------------------------------------------------------------
  // Mode selection
  // ---------------------------------------------------------------
  assign soft_rst   = wr_stb & hit(spi_addr, `RMS_ADDR_OP_MODE) & spi_wdata[`RMS_OPM_SOFT_RST];
  assign want_rx    = op_mode_q[`RMS_OPM_RX_REQ];
  assign want_pll   = want_rx | op_mode_q[`RMS_OPM_SYNTH_KEEP];
  // Tune forces the crystal without its keep-on bit
  assign want_main  = want_pll | op_mode_q[`RMS_OPM_XTAL_KEEP];
  assign sensor_sel = ~want_main & op_mode_q[`RMS_OPM_BATT_MON];
  assign sleep_sel  = ~want_main & ~sensor_sel & op_mode_q[`RMS_OPM_WAKE_TMR];
  assign cps        = (state_q == S_RX) ? `RMS_CPS_RX :
                      (state_q == S_LOCK) ? `RMS_CPS_TUNE : `RMS_CPS_IDLE;

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (reset || soft_rst) begin
      op_mode_q  <= `RMS_OPM_RESET;
      cal_ctrl_q <= `RMS_CAL_RESET;
      mask_a_q   <= `RMS_MASK_A_RESET;
      mask_b_q   <= `RMS_MASK_B_RESET;
      freq_chg_q <= 1'b0;
    end else begin
      if (wr_stb) begin
        if (hit(spi_addr, `RMS_ADDR_OP_MODE)) begin
          // Zero write leaves only the low-power regulator
          op_mode_q <= spi_wdata;
        end
        if (hit(spi_addr, `RMS_ADDR_CAL_CTRL)) begin
          cal_ctrl_q <= spi_wdata;
        end
        if (hit(spi_addr, `RMS_ADDR_MASK_A)) begin
          mask_a_q <= spi_wdata & `RMS_FLAGS_A_USED;
        end
        if (hit(spi_addr, `RMS_ADDR_MASK_B)) begin
          mask_b_q <= spi_wdata;
        end
      end
      // Set wins over the clear taken on entry to the PLL step
      if (wr_stb && (hit(spi_addr, `RMS_ADDR_FREQ_BAND) || hit(spi_addr, `RMS_ADDR_FREQ_HI) ||
          hit(spi_addr, `RMS_ADDR_FREQ_LO) || hit(spi_addr, `RMS_ADDR_HOP_STEP) ||
          hit(spi_addr, `RMS_ADDR_HOP_CHAN))) begin
        freq_chg_q <= 1'b1;
      end else if (state_q == S_PLL) begin
        freq_chg_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Interrupt flags
  // ---------------------------------------------------------------
  assign set_a = evt_a & `RMS_FLAGS_A_USED;
  assign set_b = evt_b | ({7'h00, por_pend_q} << `RMS_FLAG_B_POWER_UP)
                       | ({7'h00, chip_rdy_evt} << `RMS_FLAG_B_CHIP_RDY);

  always @(posedge clk) begin
    if (reset || soft_rst) begin
      flags_a_q  <= 8'h00;
      flags_b_q  <= 8'h00;
      por_pend_q <= 1'b1;
    end else begin
      por_pend_q <= 1'b0;
      // Enabled bits clear on read; new events in the same cycle survive
      if (rd_stb && hit(spi_addr, `RMS_ADDR_FLAGS_A)) begin
        flags_a_q <= (flags_a_q & ~mask_a_q) | set_a;
      end else begin
        flags_a_q <= flags_a_q | set_a;
      end
      if (rd_stb && hit(spi_addr, `RMS_ADDR_FLAGS_B)) begin
        flags_b_q <= (flags_b_q & ~mask_b_q) | set_b;
      end else begin
        flags_b_q <= flags_b_q | set_b;
      end
    end
  end

  // Pin follows the enabled pending set; released by the clearing read
  always @(posedge clk) begin
    if (reset) begin
      irq_n_q <= 1'b1;
    end else begin
      irq_n_q <= ~(|(flags_a_q & mask_a_q) | |(flags_b_q & mask_b_q));
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  // Captured before the clear so the host sees the events it clears
  always @(posedge clk) begin
    if (reset) begin
      rdata_q <= 8'h00;
    end else if (rd_stb) begin
      case (spi_addr)
        `RMS_ADDR_DEV_STATE: rdata_q <= {fifo_overflow, fifo_underflow, rx_fifo_empty, 1'b0,
                                         freq_error, 1'b0, cps};
        `RMS_ADDR_FLAGS_A:   rdata_q <= flags_a_q;
        `RMS_ADDR_FLAGS_B:   rdata_q <= flags_b_q;
        `RMS_ADDR_MASK_A:    rdata_q <= mask_a_q;
        `RMS_ADDR_MASK_B:    rdata_q <= mask_b_q;
        `RMS_ADDR_OP_MODE:   rdata_q <= op_mode_q;
        `RMS_ADDR_CAL_CTRL:  rdata_q <= cal_ctrl_q;
        default:             rdata_q <= 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always @* begin
    state_d      = state_q;
    tmr_load     = 1'b0;
    tmr_val      = {TW{1'b0}};
    chip_rdy_evt = 1'b0;
    case (state_q)
      S_OFF: begin
        if (want_main) begin
          state_d = S_REG;
        end
      end
      S_REG: begin
        tmr_load = 1'b1;
        tmr_val  = XTAL_LD;
        state_d  = S_XTAL;
      end
      S_XTAL: begin
        if (!want_main) begin
          state_d = S_OFF;
        end else if (tmr_done) begin
          chip_rdy_evt = 1'b1;
          state_d      = S_XTAL_ON;
        end
      end
      S_XTAL_ON: begin
        if (!want_main) begin
          state_d = S_OFF;
        end else if (want_pll) begin
          state_d = S_PLL;
        end
      end
      S_PLL: begin
        tmr_load = 1'b1;
        tmr_val  = BIAS_LD;
        state_d  = S_BIAS;
      end
      S_BIAS: begin
        if (!want_pll) begin
          state_d = S_XTAL_ON;
        end else if (tmr_done) begin
          tmr_load = 1'b1;
          if (cal_ctrl_q[`RMS_CAL_VCO_EN]) begin
            tmr_val = CAL_LD;
            state_d = S_CAL;
          end else begin
            tmr_val = SETTLE_LD;
            state_d = S_SETTLE;
          end
        end
      end
      S_CAL: begin
        // Calibration is cut short to hold the 200 us budget
        if (!want_pll) begin
          state_d = S_XTAL_ON;
        end else if (vco_cal_done || tmr_done) begin
          tmr_load = 1'b1;
          tmr_val  = SETTLE_LD;
          state_d  = S_SETTLE;
        end
      end
      S_SETTLE: begin
        if (!want_pll) begin
          state_d = S_XTAL_ON;
        end else if (tmr_done) begin
          state_d = S_LOCK;
        end
      end
      S_LOCK: begin
        if (!want_pll) begin
          state_d = S_XTAL_ON;
        end else if (freq_chg_q) begin
          state_d = S_PLL;
        end else if (want_rx) begin
          state_d = S_RXEN;
        end
      end
      S_RXEN: begin
        state_d = want_rx ? S_ADCCAL : S_LOCK;
      end
      S_ADCCAL: begin
        if (!want_rx) begin
          state_d = S_LOCK;
        end else if (adc_cal_done) begin
          state_d = S_RX;
        end
      end
      S_RX: begin
        // Frequency change restarts the PLL step; recalibrates only if cal_ctrl_q enables the VCO calibration
        if (freq_chg_q) begin
          state_d = S_PLL;
        end else if (!want_rx) begin
          state_d = S_LOCK;
        end
      end
      default: begin
        state_d = S_OFF;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // State and power outputs
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (reset || soft_rst) begin
      state_q               <= S_OFF;
      low_power_regulator_q <= 1'b1;
      main_regulator_q      <= 1'b0;
      wake_timer_en_q       <= 1'b0;
      batt_detect_en_q      <= 1'b0;
      xtal_en_q             <= 1'b0;
      pll_en_q              <= 1'b0;
      vco_cal_req_q         <= 1'b0;
      rx_frontend_en_q      <= 1'b0;
      adc_cal_req_q         <= 1'b0;
      modem_rx_en_q         <= 1'b0;
    end else begin
      state_q               <= state_d;
      // Low-power regulator only carries S_OFF (off, sleep and sensor modes)
      low_power_regulator_q <= (state_d == S_OFF);
      main_regulator_q      <= (state_d != S_OFF);
      wake_timer_en_q       <= (state_d == S_OFF) & (sleep_sel | sensor_sel);
      batt_detect_en_q      <= (state_d == S_OFF) & sensor_sel;
      xtal_en_q             <= (state_d != S_OFF) & (state_d != S_REG);
      pll_en_q              <= (state_d >= S_PLL);
      vco_cal_req_q         <= (state_d == S_CAL);
      rx_frontend_en_q      <= (state_d >= S_RXEN);
      adc_cal_req_q         <= (state_d == S_ADCCAL);
      modem_rx_en_q         <= (state_d == S_RX);
    end
  end

endmodule // rms_mode_seq

/* File: rms_host.sv */
// Host model: serial master framing register reads and writes
`timescale 1ns/1ps
module rms_host (
  input  wire clk,
  output reg  sclk = 1'b0,
  output reg  sdi = 1'b1,
  output reg  sel_n = 1'b1,
  input  wire sdo
);
  // Serial clock stands still low between frames
  // Frames never set the crystal buffer override or route the converter to a pin
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic xfer(input logic [15:0] w, output logic [7:0] r);
    int i;
    sel_n <= 1'b0;
    for (i = 15; i >= 0; i--) begin
      sdi <= w[i];
      tick(20);
      sclk <= 1'b1;
      if (i < 8) r[i] = sdo;
      tick(20);
      sclk <= 1'b0;
    end
    tick(20);
    sel_n <= 1'b1;
    // Released line must not keep the last bit
    sdi <= ~w[0];
    tick(20);
  endtask
endmodule // rms_host

/* File: rms_chk_sva.sv */
// Checker for the mode sequencer outputs
`timescale 1ns/1ps
module rms_chk (
  input wire clk,
  input wire reset,
  input wire sel_n,
  input wire irq_n_q,
  input wire wake_timer_en_q,
  input wire batt_detect_en_q,
  input wire xtal_en_q,
  input wire pll_en_q,
  input wire vco_cal_req_q,
  input wire rx_frontend_en_q,
  input wire adc_cal_req_q,
  input wire modem_rx_en_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_cal_run;
    $rose(vco_cal_req_q) ##1 vco_cal_req_q;
  endsequence
  chk_rx_path: assert property (modem_rx_en_q |-> xtal_en_q && pll_en_q && rx_frontend_en_q)
    else $error("receive without full path");
  chk_tune_xtal: assert property (pll_en_q |-> xtal_en_q)
    else $error("pll on without crystal");
  chk_sleep_only: assert property (wake_timer_en_q |-> !xtal_en_q && !pll_en_q)
    else $error("sleep with crystal or pll");
  chk_batt_sensor: assert property (batt_detect_en_q |-> wake_timer_en_q)
    else $error("battery detector outside sensor");
  chk_cal_order: assert property (vco_cal_req_q |-> pll_en_q && !rx_frontend_en_q)
    else $error("vco cal out of order");
  chk_cal_bound: assert property (s_cal_run |-> ##[1:40] !vco_cal_req_q)
    else $error("vco cal too long");
  chk_adc_after: assert property ($rose(rx_frontend_en_q) |-> ##[0:3] adc_cal_req_q)
    else $error("no converter cal after front end");
  chk_irq_release: assert property ($rose(irq_n_q) |-> !$past(sel_n, 2))
    else $error("irq released without access");
endmodule // rms_chk
bind rms_mode_seq rms_chk i_rms_chk (.*);

/* File: testbench.sv */
// Self-checking bench for the mode sequencer
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] evt_b = 8'h00;
  logic [3:0] fifo = 4'h0;
  logic adc_done = 1'b0;
  logic [7:0] evt_a = 8'h00;
  logic vcal = 1'b0;
  logic fast = 1'b0;
  int ncal = 0;
  int c0;
  logic sclk, sdi, sel_n, sdo, irq, lpr, mreg, wake, batt, xtal, pll, vreq, rxfe, areq, modem;
  logic [7:0] rd;
  wire [7:0] pins = {lpr, mreg, wake, batt, xtal, pll, modem, irq};
  logic [7:0] m [5] = '{8'h00, 8'h40, 8'h60, 8'h02, 8'h04};
  logic [5:0] e [5] = '{6'h01, 6'h21, 6'h31, 6'h0D, 6'h0F};
  int miscompares = 0;
  int n_tests = 0;
  int i;
  always #2 clk = ~clk;
  always @(posedge clk) adc_done <= areq;
  // Calibrator replies only when fast is set, else the timer ends the step
  always @(posedge clk) vcal <= vreq & fast;
  always @(posedge clk) if (vreq) ncal <= ncal + 1;
  rms_host i_rms_host (.clk(clk), .sclk(sclk), .sdi(sdi), .sel_n(sel_n), .sdo(sdo));
  rms_mode_seq #(.SETTLE_CYC(20), .BIAS_CYC(5), .CAL_CYC(30), .XTAL_CYC(10)) i_rms_mode_seq (
    .clk(clk), .reset(reset), .sclk(sclk), .sdi(sdi), .sel_n(sel_n), .evt_a(evt_a), .evt_b(evt_b),
    .fifo_overflow(fifo[3]), .fifo_underflow(fifo[2]), .rx_fifo_empty(fifo[1]), .freq_error(fifo[0]),
    .vco_cal_done(vcal), .adc_cal_done(adc_done), .sdo(sdo), .irq_n_q(irq), .low_power_regulator_q(lpr),
    .main_regulator_q(mreg), .wake_timer_en_q(wake), .batt_detect_en_q(batt), .xtal_en_q(xtal),
    .pll_en_q(pll), .vco_cal_req_q(vreq), .rx_frontend_en_q(rxfe), .adc_cal_req_q(areq),
    .modem_rx_en_q(modem));
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd_reg(input logic [6:0] a, input logic [7:0] exp);
    i_rms_host.xfer({1'b0, a, 8'h00}, rd);
    cmp8(rd, exp);
  endtask
  task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
    i_rms_host.xfer({1'b1, a, d}, rd);
  endtask
  // Pins {wake, batt, xtal, pll, modem, irq}; settled main regulator follows the crystal
  task automatic await(input logic [5:0] exp);
    int n;
    for (n = 0; n < 400 && pins !== {~exp[3], exp[3], exp}; n++) @(posedge clk);
    cmp8(pins, {~exp[3], exp[3], exp});
    if (n == 400) wrap_up();
  endtask
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    await(6'h08);
    rd_reg(7'h06, 8'h01);
    rd_reg(7'h05, 8'h00);
    rd_reg(7'h04, 8'h03);
    await(6'h09);
    rd_reg(7'h04, 8'h02);
    evt_b <= 8'h08;
    @(posedge clk);
    evt_b <= 8'h00;
    repeat (4) @(posedge clk);
    await(6'h09);
    wr_reg(7'h06, 8'h09);
    await(6'h08);
    rd_reg(7'h04, 8'h0A);
    fifo <= 4'hB;
    for (i = 0; i < 5; i++) begin
      wr_reg(7'h07, m[i]);
      await(e[i]);
    end
    rd_reg(7'h02, 8'hA9);
    wr_reg(7'h07, 8'h03);
    await(6'h0D);
    rd_reg(7'h02, 8'hAA);
    wr_reg(7'h05, 8'hFF);
    rd_reg(7'h05, 8'h98);
    evt_a <= 8'h17;
    @(posedge clk);
    evt_a <= 8'h00;
    await(6'h0C);
    rd_reg(7'h03, 8'h10);
    await(6'h0D);
    c0 = ncal;
    wr_reg(7'h08, 8'h00);
    wr_reg(7'h75, 8'h00);
    rd_reg(7'h02, 8'hAA);
    cmp8(8'(ncal - c0), 8'h00);
    fast <= 1'b1;
    wr_reg(7'h08, 8'h01);
    c0 = ncal;
    wr_reg(7'h79, 8'h00);
    rd_reg(7'h02, 8'hAA);
    cmp8(8'(ncal > c0 && ncal - c0 < 10), 8'h01);
    wr_reg(7'h07, 8'h80);
    await(6'h08);
    rd_reg(7'h06, 8'h01);
    wrap_up();
  end
endmodule // testbench
